// [hdl/mct_pkg.sv]
package mct_pkg;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned NCH = 4;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic [31:0] PRE_RST = 32'h0000_0000;
  // external match output actions
  typedef enum logic [1:0] {
    MCT_EM_NONE = 2'b00,
    MCT_EM_LOW = 2'b01,
    MCT_EM_HIGH = 2'b10,
    MCT_EM_TOGGLE = 2'b11
  } mct_em_e;
  // counter input source
  typedef enum logic [1:0] {
    MCT_MODE_TIMER = 2'b00,
    MCT_MODE_RISE = 2'b01,
    MCT_MODE_FALL = 2'b10,
    MCT_MODE_BOTH = 2'b11
  } mct_mode_e;
  // capture edge select bit positions
  localparam int unsigned CAP_RISE_BIT = 0;
  localparam int unsigned CAP_FALL_BIT = 1;
  // pin combine modes
  localparam logic [1:0] MCT_COMB_OR = 2'b00;
  localparam logic [1:0] MCT_COMB_AND = 2'b01;
endpackage

// [hdl/mct_edge.sv]
`timescale 1ns/10ps
`default_nettype none
// edge detector for one capture line; inputs are synchronous already
module mct_edge (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic line_in,
  output logic rise,
  output logic fall
);
  logic prev_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= line_in;
    end
  end
  assign rise = line_in & ~prev_q;
  assign fall = ~line_in & prev_q;
endmodule
`default_nettype wire

// [hdl/mct_timer.sv]
`timescale 1ns/10ps
`default_nettype none
// Operation
// - count clock cycles in timer mode or selected input edges in counter mode
// - 32-bit count advanced through a programmable 32-bit prescaler
// - four 32-bit match values compared against the running count
// - match may let counting continue; interrupt only when enabled
// - stop-on-match holds count at that match and clears running for one cycle; counting resumes while cnt_enable stays set, interrupt optional
// - reset-on-match returns count to zero, interrupt optional
// - four capture channels latch count on selected input transition
// - capture interrupt only when enabled for that channel
// - other capture lines still capture or interrupt while one counts
// - four external outputs each driven by same-index match
// - each output goes low, high, toggles or holds on match
// - several pins combine per capture/match: OR, AND, broadcast
module mct_timer (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cnt_enable,
  input wire logic cnt_reset,
  input wire logic [1:0] cnt_mode,
  input wire logic [1:0] cnt_src_sel,
  input wire logic [31:0] prescale_val,
  input wire logic [127:0] match_val,
  input wire logic [3:0] match_irq_en,
  input wire logic [3:0] match_reset_en,
  input wire logic [3:0] match_stop_en,
  input wire logic [7:0] ext_action,
  input wire logic [3:0] cap_pin_a,
  input wire logic [3:0] cap_pin_b,
  input wire logic [3:0] cap_pin_use_b,
  input wire logic [1:0] cap_comb,
  input wire logic [7:0] cap_edge_sel,
  input wire logic [3:0] cap_irq_en,
  output logic [31:0] count,
  output logic [31:0] prescale_count,
  output logic running,
  output logic [127:0] capture_val,
  output logic [3:0] match_irq,
  output logic [3:0] cap_irq,
  output logic [3:0] ext_match,
  output logic [7:0] match_pin
);
  logic [31:0] tc_q;
  logic [31:0] pc_q;
  logic run_q;
  logic [127:0] cap_q;
  logic [3:0] mirq_q;
  logic [3:0] cirq_q;
  logic [3:0] em_q;
  logic [3:0] cap_line;
  logic [3:0] cap_rise;
  logic [3:0] cap_fall;
  logic [3:0] cap_hit;
  logic [3:0] match_hit;
  logic [3:0] match_eq;
  // a match acts once per arrival at the value, not on every cycle spent
  // there, since with a prescaler the count rests on a value for many cycles
  logic [3:0] hit_seen_q;
  logic src_rise;
  logic src_fall;
  logic count_tick;
  logic pre_wrap;
  logic do_reset;
  logic do_stop;

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_ch
      // two pins per function: or/and combine, or one pin alone
      assign cap_line[i] = !cap_pin_use_b[i] ? cap_pin_a[i] :
        (cap_comb == mct_pkg::MCT_COMB_AND) ?
        (cap_pin_a[i] & cap_pin_b[i]) :
        (cap_pin_a[i] | cap_pin_b[i]);
      mct_edge u_edge (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .line_in(cap_line[i]),
        .rise(cap_rise[i]),
        .fall(cap_fall[i])
      );
      // source line in counter mode may still capture
      assign cap_hit[i] =
        (cap_edge_sel[2*i+mct_pkg::CAP_RISE_BIT] & cap_rise[i]) |
        (cap_edge_sel[2*i+mct_pkg::CAP_FALL_BIT] & cap_fall[i]);
      assign match_eq[i] = (tc_q == match_val[32*i +: 32]);
      assign match_hit[i] = run_q && match_eq[i] &&
        !hit_seen_q[i];
      // broadcast: each match output appears on two pins
      assign match_pin[2*i] = em_q[i];
      assign match_pin[2*i+1] = em_q[i];
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          cap_q[32*i +: 32] <= mct_pkg::CNT_RST;
          cirq_q[i] <= 1'b0;
          mirq_q[i] <= 1'b0;
          em_q[i] <= 1'b0;
          hit_seen_q[i] <= 1'b0;
        end else begin
          hit_seen_q[i] <= match_hit[i] | (hit_seen_q[i] & match_eq[i]);
          if (cap_hit[i]) begin
            cap_q[32*i +: 32] <= tc_q;
          end
          cirq_q[i] <= cap_hit[i] & cap_irq_en[i];
          mirq_q[i] <= match_hit[i] & match_irq_en[i];
          if (match_hit[i]) begin
            unique case (mct_pkg::mct_em_e'(ext_action[2*i +: 2]))
              mct_pkg::MCT_EM_NONE: em_q[i] <= em_q[i];
              mct_pkg::MCT_EM_LOW: em_q[i] <= 1'b0;
              mct_pkg::MCT_EM_HIGH: em_q[i] <= 1'b1;
              mct_pkg::MCT_EM_TOGGLE: em_q[i] <= ~em_q[i];
            endcase
          end
        end
      end
    end
  endgenerate

  assign src_rise = cap_rise[cnt_src_sel];
  assign src_fall = cap_fall[cnt_src_sel];
  // events are single clock edges; pulses below one period may be lost
  assign count_tick = run_q && (
    (cnt_mode == mct_pkg::MCT_MODE_TIMER) ||
    (cnt_mode == mct_pkg::MCT_MODE_RISE && src_rise) ||
    (cnt_mode == mct_pkg::MCT_MODE_FALL && src_fall) ||
    (cnt_mode == mct_pkg::MCT_MODE_BOTH && (src_rise | src_fall)));
  assign pre_wrap = count_tick && (pc_q >= prescale_val);
  assign do_reset = |(match_hit & match_reset_en);
  assign do_stop = |(match_hit & match_stop_en);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tc_q <= mct_pkg::CNT_RST;
      pc_q <= mct_pkg::PRE_RST;
      run_q <= 1'b0;
    end else begin
      run_q <= cnt_enable & ~do_stop;
      if (cnt_reset || do_reset) begin
        tc_q <= mct_pkg::CNT_RST;
        pc_q <= mct_pkg::PRE_RST;
      end else if (do_stop) begin
        tc_q <= tc_q;
      end else if (pre_wrap) begin
        pc_q <= mct_pkg::PRE_RST;
        tc_q <= tc_q + 32'h0000_0001;
      end else if (count_tick) begin
        pc_q <= pc_q + 32'h0000_0001;
      end
    end
  end

  assign count = tc_q;
  assign prescale_count = pc_q;
  assign running = run_q;
  assign capture_val = cap_q;
  assign match_irq = mirq_q;
  assign cap_irq = cirq_q;
  assign ext_match = em_q;

  sequence s_wrap;
    pre_wrap && !cnt_reset && !do_reset && !do_stop;
  endsequence
  property p_incr;
    @(posedge sys_clk) disable iff (!rst_n)
      s_wrap |=> (tc_q == $past(tc_q) + 32'h0000_0001) && pc_q == 32'h0;
  endproperty
  a_incr: assert property (p_incr) else $error("count not incremented");
  property p_stop;
    @(posedge sys_clk) disable iff (!rst_n)
      do_stop && !cnt_reset && !do_reset |=> !run_q && $stable(tc_q);
  endproperty
  a_stop: assert property (p_stop) else $error("stop failed");
  property p_reset;
    @(posedge sys_clk) disable iff (!rst_n)
      do_reset |=> tc_q == 32'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset failed");
  property p_mirq;
    @(posedge sys_clk) disable iff (!rst_n)
      match_irq[0] |-> $past(match_hit[0]) && $past(match_irq_en[0]);
  endproperty
  a_mirq: assert property (p_mirq) else $error("bad match irq");
  property p_cirq;
    @(posedge sys_clk) disable iff (!rst_n)
      cap_irq[1] |-> $past(cap_hit[1]) && $past(cap_irq_en[1]);
  endproperty
  a_cirq: assert property (p_cirq) else $error("bad capture irq");
  property p_cap;
    @(posedge sys_clk) disable iff (!rst_n)
      cap_hit[0] |=> capture_val[31:0] == $past(tc_q);
  endproperty
  a_cap: assert property (p_cap) else $error("capture wrong");
  property p_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      !run_q && !cnt_reset |=> $stable(tc_q);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved");
  property p_toggle;
    @(posedge sys_clk) disable iff (!rst_n)
      match_hit[2] && ext_action[5:4] == 2'h3 |=> ext_match[2] != $past(em_q[2]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");
  property p_high;
    @(posedge sys_clk) disable iff (!rst_n)
      match_hit[3] && ext_action[7:6] == 2'h2 |=> ext_match[3];
  endproperty
  a_high: assert property (p_high) else $error("not set high");

  sequence s_quiet;
    !cnt_reset && !do_reset && !do_stop;
  endsequence

  sequence s_pre_step;
    count_tick && !pre_wrap;
  endsequence

  property p_pre_step;
    @(posedge sys_clk) disable iff (!rst_n)
      s_pre_step ##0 s_quiet |=>
        pc_q == $past(pc_q) + 32'h0000_0001 && $stable(tc_q);
  endproperty
  a_pre_step: assert property (p_pre_step) else $error("no step");

  property p_low;
    @(posedge sys_clk) disable iff (!rst_n)
      match_hit[1] && ext_action[3:2] == 2'h1 |=> !ext_match[1];
  endproperty
  a_low: assert property (p_low) else $error("not set low");

  property p_none;
    @(posedge sys_clk) disable iff (!rst_n)
      match_hit[0] && ext_action[1:0] == 2'h0 |=> $stable(ext_match[0]);
  endproperty
  a_none: assert property (p_none) else $error("output moved");

  property p_em_idle;
    @(posedge sys_clk) disable iff (!rst_n)
      !match_hit[1] |=> $stable(ext_match[1]);
  endproperty
  a_em_idle: assert property (p_em_idle) else $error("output drift");

  property p_once;
    @(posedge sys_clk) disable iff (!rst_n)
      match_hit[0] |=> !match_hit[0];
  endproperty
  a_once: assert property (p_once) else $error("match repeated");

  property p_clr;
    @(posedge sys_clk) disable iff (!rst_n)
      cnt_reset |=> tc_q == 32'h0 && pc_q == 32'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear failed");

  property p_run_on;
    @(posedge sys_clk) disable iff (!rst_n)
      cnt_enable && !do_stop |=> run_q;
  endproperty
  a_run_on: assert property (p_run_on) else $error("not running");

  property p_run_off;
    @(posedge sys_clk) disable iff (!rst_n)
      !cnt_enable |=> !run_q;
  endproperty
  a_run_off: assert property (p_run_off) else $error("still running");

  property p_cap_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      !cap_hit[2] |=> $stable(capture_val[95:64]);
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture drift");

  property p_cirq_on;
    @(posedge sys_clk) disable iff (!rst_n)
      cap_hit[3] && cap_irq_en[3] |=> cap_irq[3];
  endproperty
  a_cirq_on: assert property (p_cirq_on) else $error("capture irq lost");

  property p_mirq_on;
    @(posedge sys_clk) disable iff (!rst_n)
      match_hit[1] && match_irq_en[1] |=> match_irq[1];
  endproperty
  a_mirq_on: assert property (p_mirq_on) else $error("match irq lost");

  property p_stop_irq;
    @(posedge sys_clk) disable iff (!rst_n)
      do_stop && |(match_hit & match_irq_en) |=> |match_irq;
  endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("stop irq lost");

  property p_reset_irq;
    @(posedge sys_clk) disable iff (!rst_n)
      do_reset && |(match_hit & match_irq_en) |=> |match_irq;
  endproperty
  a_reset_irq: assert property (p_reset_irq) else $error("reset irq");

  sequence s_free;
    run_q && cnt_mode == mct_pkg::MCT_MODE_TIMER;
  endsequence

  property p_timer;
    @(posedge sys_clk) disable iff (!rst_n)
      s_free ##0 s_quiet |=>
        pc_q != $past(pc_q) || tc_q != $past(tc_q) || pc_q == 32'h0;
  endproperty
  a_timer: assert property (p_timer) else $error("timer idle");

  property p_tc_step;
    @(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> tc_q == $past(tc_q) || tc_q == 32'h0 ||
        tc_q == $past(tc_q) + 32'h0000_0001;
  endproperty
  a_tc_step: assert property (p_tc_step) else $error("count jumped");

  // a capture line stays usable while another line feeds the count
  property p_side_cap;
    @(posedge sys_clk) disable iff (!rst_n)
      cap_hit[1] && cnt_src_sel != 2'h1 |=>
        capture_val[63:32] == $past(tc_q);
  endproperty
  a_side_cap: assert property (p_side_cap) else $error("side capture");

  property p_pin_pair;
    @(posedge sys_clk) disable iff (!rst_n)
      1'b1 |-> match_pin[5:4] == {2{ext_match[2]}};
  endproperty
  a_pin_pair: assert property (p_pin_pair) else $error("broadcast");
endmodule
`default_nettype wire

// [dv/mct_pins.sv]
`timescale 1ns/10ps
`default_nettype none
// far-side event source: each request becomes a pulse two clocks long
module mct_pins (
  input wire logic sys_clk,
  input wire logic [3:0] fire,
  output logic [3:0] pins
);
  logic [1:0] hold_q [4];
  initial for (int i = 0; i < 4; i++) hold_q[i] = 2'h0;
  always @(posedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      // never shorter than one clock, so no event is lost
      if (fire[i]) hold_q[i] <= 2'h2;
      else if (hold_q[i] != 2'h0) hold_q[i] <= hold_q[i] - 2'h1;
    end
  end
  always_comb for (int i = 0; i < 4; i++) pins[i] = hold_q[i] != 2'h0;
endmodule
`default_nettype wire

// [dv/test_match_capture_timer32.sv]
`timescale 1ns/10ps
`default_nettype none
module test_match_capture_timer32;
  logic sys_clk = 0, rst_n = 0, en = 0, clr = 0, running;
  logic [1:0] mode = 0, src = 0;
  logic [31:0] pre = 0, count, pc;
  logic [127:0] mv = 0, cv;
  logic [3:0] irqe = 0, rste = 0, stpe = 0, fire = 0, capie = 0;
  logic [3:0] mirq, cirq, ext, pins, e;
  logic [7:0] act = 0, edg = 0, mpin;
  int failures = 0, check_count = 0, seed = 32'h3ff355d5, n, k, p, m, c;
  always #25 sys_clk = ~sys_clk;
  mct_pins u_pins (.sys_clk(sys_clk), .fire(fire), .pins(pins));
  mct_timer u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cnt_enable(en),
    .cnt_reset(clr), .cnt_mode(mode), .cnt_src_sel(src),
    .prescale_val(pre), .match_val(mv), .match_irq_en(irqe),
    .match_reset_en(rste), .match_stop_en(stpe), .ext_action(act),
    .cap_pin_a(pins), .cap_pin_b(4'h0), .cap_pin_use_b(4'h0),
    .cap_comb(2'h0), .cap_edge_sel(edg), .cap_irq_en(capie),
    .count(count), .prescale_count(pc), .running(running),
    .capture_val(cv), .match_irq(mirq), .cap_irq(cirq), .ext_match(ext),
    .match_pin(mpin));
  task tick;
    @(posedge sys_clk);
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // cycles from one count change to the next
  task step(output int cy);
    logic [31:0] v;
    v = count;
    cy = 0;
    do begin
      tick;
      cy++;
    end while (count === v && cy < 50);
  endtask
  function automatic logic [7:0] pins_of(input logic [3:0] x);
    for (int i = 0; i < 4; i++) pins_of[2*i+:2] = {2{x[i]}};
  endfunction
  task tally_and_finish;
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    tally_and_finish;
  end
  initial begin
    repeat (12) tick;
    rst_n <= 1;
    en <= 1;
    for (k = 0; k < 4; k++) begin
      p = k == 0 ? 0 : $unsigned($random(seed)) % 5;
      pre <= p;
      step(c);
      step(c);
      chk(c, p + 1);
      chk(pc, 0);
    end
    pre <= 0;
    clr <= 1;
    tick;
    clr <= 0;
    m = 3 + $unsigned($random(seed)) % 8;
    mv <= {4{m[31:0]}};
    rste <= 4'h1;
    irqe <= 4'h1;
    act <= {mct_pkg::MCT_EM_TOGGLE, mct_pkg::MCT_EM_HIGH,
      mct_pkg::MCT_EM_LOW, mct_pkg::MCT_EM_NONE};
    e = 4'h0;
    for (k = 0; k < 4; k++) begin
      for (c = 0; c < 100 && mirq[0] !== 1'b1; c++) tick;
      if (k > 0) chk(c, m);
      e = {~e[3], 3'b100};
      chk(mirq, 4'h1);
      chk(count, 0);
      chk(ext, e);
      chk(mpin, pins_of(e));
      tick;
    end
    // line 3 captures silently, line 1 also interrupts
    rste <= 4'h0;
    mv <= {4{32'hffff_ff00}};
    edg <= 8'h44;
    capie <= 4'h2;
    fire <= 4'ha;
    tick;
    fire <= 4'h0;
    for (c = 0; c < 20 && cirq[1] !== 1'b1; c++) tick;
    chk(cirq, 4'h2);
    chk(cv[63:32], count - 1);
    chk(cv[127:96], cv[63:32]);
    chk(cv[31:0], 0);
    clr <= 1;
    mode <= mct_pkg::MCT_MODE_RISE;
    tick;
    clr <= 0;
    edg <= 8'h10;
    capie <= 4'h4;
    n = 2 + $unsigned($random(seed)) % 4;
    for (k = 0; k < n; k++) begin
      fire <= 4'h1;
      tick;
      fire <= 4'h0;
      repeat (4) tick;
    end
    chk(count, n);
    fire <= 4'h4;
    tick;
    fire <= 4'h0;
    for (c = 0; c < 20 && cirq[2] !== 1'b1; c++) tick;
    chk(cv[95:64], n);
    mode <= mct_pkg::MCT_MODE_TIMER;
    clr <= 1;
    tick;
    clr <= 0;
    mv[63:32] <= m;
    stpe <= 4'h2;
    for (c = 0; c < 100 && running !== 1'b0; c++) tick;
    en <= 0;
    chk(count, m);
    chk(mirq, 4'h0);
    chk(running, 0);
    repeat (3) tick;
    chk(count, m);
    tally_and_finish;
  end
endmodule
`default_nettype wire
